/* design/status_srq_map.svh */
`ifndef STATUS_SRQ_MAP_SVH
`define STATUS_SRQ_MAP_SVH

// ****************************************
// status byte field positions
// ****************************************
`define SB_ERROR_AVAIL  0
`define SB_PRINT_AVAIL  1
`define SB_LINE_SUM     2
`define SB_INTF_SUM     3
`define SB_MSG_AVAIL    4
`define SB_EVENT_SUM    5
`define SB_MASTER_SUM   6
`define SB_UNUSED       7

// ****************************************
// event status bits, group indices, reset values
// ****************************************
`define ESR_QUERY_ERR   2
`define GRP_LINE        0
`define GRP_INTF        1
`define GRP_COUNT       2
`define ENABLE_RESET    8'h00
`define FLAGS_RESET     8'h00
`define BYTE_ZERO       8'h00

`endif

/* design/status_srq_pkg.sv */
package status_srq_pkg;

    typedef enum logic [4:0] {
        CMD_NONE     = 5'b00000,
        CMD_CLEAR    = 5'b00001,
        CMD_CLR_ERR  = 5'b00010,
        CMD_WR_SRE   = 5'b00011,
        CMD_WR_ESE   = 5'b00100,
        CMD_WR_LHE   = 5'b00101,
        CMD_WR_LLE   = 5'b00110,
        CMD_WR_IHE   = 5'b00111,
        CMD_WR_ILE   = 5'b01000,
        CMD_RD_STB   = 5'b01001,
        CMD_RD_ESR   = 5'b01010,
        CMD_RD_LINE  = 5'b01011,
        CMD_RD_LHIST = 5'b01100,
        CMD_RD_LLOSS = 5'b01101,
        CMD_RD_INTF  = 5'b01110,
        CMD_RD_IHIST = 5'b01111,
        CMD_RD_ILOSS = 5'b10000,
        CMD_RD_SRE   = 5'b10001,
        CMD_RD_ESE   = 5'b10010,
        CMD_RD_LHE   = 5'b10011,
        CMD_RD_LLE   = 5'b10100,
        CMD_RD_IHE   = 5'b10101,
        CMD_RD_ILE   = 5'b10110
    } cmd_t;

    typedef struct packed {
        logic       valid;
        cmd_t       code;
        logic [7:0] data;
    } cmd_req_t;

    typedef struct packed {
        logic [7:0] hist;
        logic [7:0] loss;
        logic [7:0] hist_en;
        logic [7:0] loss_en;
    } group_t;

endpackage

/* design/status_reporting_srq.sv */
`timescale 1ns/10ps
`include "status_srq_map.svh"

// Contract
// RULE1: each group holds an 8-bit status register, one bit per event.
// RULE2: history bit sets on off-to-on change; loss bit on on-to-off change.
// RULE3: history and loss registers accumulate all changes between reads.
// RULE4: each group has 8-bit enable registers written by command.
// RULE5: group summary is OR of status bits ANDed with enables.
// RULE6: line and interface summaries OR enabled loss and enabled history terms.
// RULE7: clear-status clears all events, buffers and queues except output queue.
// RULE8: responses queue; serial sends at once, parallel waits for talker addressing.
// RULE9: status byte bit 4 is one while the output queue holds responses.
// RULE10: bit 1 is one while a printout waits; printouts enter only when remote.
// RULE11: error buffer keeps the latest error; command clears it; bit 0 flags it.
// RULE12: status byte bit 7 always reads zero.
// RULE13: bit 6 is request-service on serial poll, master summary on query.
// RULE14: master summary ORs enabled status bits; its own enable is fixed.
// RULE15: master summary becoming one asserts the service request line.
// RULE16: status byte bit 5 is one when an enabled standard event is set.
// RULE17: on the parallel bus no talker data until message-available is one.
// RULE18: interface summary at bit 3, line summary at bit 2.
// RULE19: status byte read returns the bits as a weighted binary integer.
// RULE20: reading the standard event register clears it.
// RULE21: 8-bit event enable; enabled set event forces event-summary bit.
// RULE22: history/loss read clears atomically; same-cycle events survive for next read.
// RULE23: all enable registers reset to zero.
module status_reporting_srq
    import status_srq_pkg::*;
#(
    parameter int QCOUNT_W = 4
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire cmd_req_t   cmd,
    input  wire logic       serial_poll,
    input  wire logic [7:0] line_level_pin,
    input  wire logic [7:0] intf_level_pin,
    input  wire logic [7:0] std_event,
    input  wire logic       resp_push,
    input  wire logic       resp_pop,
    input  wire logic       serial_mode,
    input  wire logic       talker_addressed,
    input  wire logic       print_push,
    input  wire logic       print_pop,
    input  wire logic       print_remote,
    input  wire logic       error_post,
    output logic            rsp_valid,
    output logic [7:0]      rsp_data,
    output logic            srq,
    output logic            talker_drive,
    output logic            serial_send
);

    // ****************************************
    // level synchronisers
    // ****************************************
    logic [7:0] line_meta, line_sync, line_prev;
    logic [7:0] intf_meta, intf_sync, intf_prev;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_meta <= `FLAGS_RESET;
            line_sync <= `FLAGS_RESET;
            line_prev <= `FLAGS_RESET;
            intf_meta <= `FLAGS_RESET;
            intf_sync <= `FLAGS_RESET;
            intf_prev <= `FLAGS_RESET;
        end else begin
            line_meta <= line_level_pin;
            line_sync <= line_meta;
            line_prev <= line_sync;
            intf_meta <= intf_level_pin;
            intf_sync <= intf_meta;
            intf_prev <= intf_sync;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic masked_any(input logic [7:0] bits, input logic [7:0] en);
        masked_any = |(bits & en); // RULE5
    endfunction

    function automatic logic [7:0] accumulate(input logic [7:0] cur, input logic rd,
                                              input logic [7:0] ev);
        // new events are or-ed in after the clear so they survive the read
        accumulate = (rd ? `BYTE_ZERO : cur) | ev; // RULE3 RULE22
    endfunction

    // ****************************************
    // state
    // ****************************************
    group_t              grp [`GRP_COUNT];
    group_t              next_grp [`GRP_COUNT];
    logic [7:0]          level [`GRP_COUNT];
    logic [7:0]          rise [`GRP_COUNT];
    logic [7:0]          fall [`GRP_COUNT];
    logic [`GRP_COUNT-1:0] grp_sum;
    logic [7:0]          esr, next_esr, ese, next_ese, sre, next_sre;
    logic [QCOUNT_W-1:0] out_count, next_out_count, print_count, next_print_count;
    logic                error_held, next_error_held;
    logic                rqs, next_rqs, mss_q;
    logic                next_rsp_valid, next_talker_drive, next_serial_send;
    logic [7:0]          next_rsp_data, stb, base_stb;
    logic                mss, esb, clear_all;
    logic                rd_lhist, rd_lloss, rd_ihist, rd_iloss;

    assign level[`GRP_LINE] = line_sync;
    assign level[`GRP_INTF] = intf_sync;
    assign rise[`GRP_LINE]  = line_sync & ~line_prev; // RULE2
    assign fall[`GRP_LINE]  = ~line_sync & line_prev; // RULE2
    assign rise[`GRP_INTF]  = intf_sync & ~intf_prev;
    assign fall[`GRP_INTF]  = ~intf_sync & intf_prev;

    genvar g;
    generate
        for (g = 0; g < `GRP_COUNT; g++) begin : g_sum
            assign grp_sum[g] = masked_any(grp[g].hist, grp[g].hist_en)
                              | masked_any(grp[g].loss, grp[g].loss_en); // RULE6
        end
    endgenerate

    // ****************************************
    // status byte
    // ****************************************
    assign esb = masked_any(esr, ese); // RULE16 RULE21
    always_comb begin
        base_stb                  = `BYTE_ZERO; // RULE12
        base_stb[`SB_ERROR_AVAIL] = error_held; // RULE11
        base_stb[`SB_PRINT_AVAIL] = print_count != '0; // RULE10
        base_stb[`SB_LINE_SUM]    = grp_sum[`GRP_LINE]; // RULE18
        base_stb[`SB_INTF_SUM]    = grp_sum[`GRP_INTF]; // RULE18
        base_stb[`SB_MSG_AVAIL]   = out_count != '0; // RULE9
        base_stb[`SB_EVENT_SUM]   = esb;
        // sre bit 6 is held at zero, so master summary never feeds itself
        mss                       = masked_any(base_stb, sre); // RULE14
        stb                       = base_stb;
        stb[`SB_MASTER_SUM]       = mss;
    end

    assign clear_all = cmd.valid && cmd.code == CMD_CLEAR;
    assign rd_lhist  = cmd.valid && cmd.code == CMD_RD_LHIST;
    assign rd_lloss  = cmd.valid && cmd.code == CMD_RD_LLOSS;
    assign rd_ihist  = cmd.valid && cmd.code == CMD_RD_IHIST;
    assign rd_iloss  = cmd.valid && cmd.code == CMD_RD_ILOSS;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_grp = grp;
        next_grp[`GRP_LINE].hist = accumulate(grp[`GRP_LINE].hist, rd_lhist | clear_all,
                                              rise[`GRP_LINE]); // RULE1 RULE7
        next_grp[`GRP_LINE].loss = accumulate(grp[`GRP_LINE].loss, rd_lloss | clear_all,
                                              fall[`GRP_LINE]);
        next_grp[`GRP_INTF].hist = accumulate(grp[`GRP_INTF].hist, rd_ihist | clear_all,
                                              rise[`GRP_INTF]);
        next_grp[`GRP_INTF].loss = accumulate(grp[`GRP_INTF].loss, rd_iloss | clear_all,
                                              fall[`GRP_INTF]);
        next_esr = accumulate(esr, clear_all || (cmd.valid && cmd.code == CMD_RD_ESR),
                              std_event); // RULE20
        if (resp_pop && out_count == '0) begin
            next_esr[`ESR_QUERY_ERR] = 1'b1;
        end
        next_ese = ese;
        next_sre = sre;
        next_rsp_valid = 1'b0;
        next_rsp_data  = `BYTE_ZERO;
        if (cmd.valid) begin
            next_rsp_valid = 1'b1;
            case (cmd.code)
                CMD_WR_SRE: begin
                    next_sre                 = cmd.data; // RULE4
                    next_sre[`SB_MASTER_SUM] = 1'b0; // RULE14
                    next_rsp_valid           = 1'b0;
                end
                CMD_WR_ESE: begin
                    next_ese       = cmd.data; // RULE21
                    next_rsp_valid = 1'b0;
                end
                CMD_WR_LHE: begin
                    next_grp[`GRP_LINE].hist_en = cmd.data; // RULE4
                    next_rsp_valid              = 1'b0;
                end
                CMD_WR_LLE: begin
                    next_grp[`GRP_LINE].loss_en = cmd.data;
                    next_rsp_valid              = 1'b0;
                end
                CMD_WR_IHE: begin
                    next_grp[`GRP_INTF].hist_en = cmd.data;
                    next_rsp_valid              = 1'b0;
                end
                CMD_WR_ILE: begin
                    next_grp[`GRP_INTF].loss_en = cmd.data;
                    next_rsp_valid              = 1'b0;
                end
                CMD_RD_STB:   next_rsp_data = stb; // RULE13 RULE19
                CMD_RD_ESR:   next_rsp_data = esr;
                CMD_RD_LINE:  next_rsp_data = level[`GRP_LINE];
                CMD_RD_LHIST: next_rsp_data = grp[`GRP_LINE].hist;
                CMD_RD_LLOSS: next_rsp_data = grp[`GRP_LINE].loss;
                CMD_RD_INTF:  next_rsp_data = level[`GRP_INTF];
                CMD_RD_IHIST: next_rsp_data = grp[`GRP_INTF].hist;
                CMD_RD_ILOSS: next_rsp_data = grp[`GRP_INTF].loss;
                CMD_RD_SRE:   next_rsp_data = sre;
                CMD_RD_ESE:   next_rsp_data = ese;
                CMD_RD_LHE:   next_rsp_data = grp[`GRP_LINE].hist_en;
                CMD_RD_LLE:   next_rsp_data = grp[`GRP_LINE].loss_en;
                CMD_RD_IHE:   next_rsp_data = grp[`GRP_INTF].hist_en;
                CMD_RD_ILE:   next_rsp_data = grp[`GRP_INTF].loss_en;
                default:      next_rsp_valid = 1'b0;
            endcase
        end
        if (serial_poll) begin
            // a poll in the same cycle as a command takes the answer slot
            next_rsp_valid                = 1'b1;
            next_rsp_data                 = stb;
            next_rsp_data[`SB_MASTER_SUM] = rqs; // RULE13
        end

        // output queue survives the clear-status command
        next_out_count = out_count;
        if (resp_push && !resp_pop && out_count != '1) begin
            next_out_count = out_count + 1'b1; // RULE8
        end else if (resp_pop && !resp_push && out_count != '0) begin
            next_out_count = out_count - 1'b1;
        end

        next_print_count = clear_all ? '0 : print_count; // RULE7
        if (print_pop && next_print_count != '0) begin
            next_print_count = next_print_count - 1'b1;
        end
        if (print_push && print_remote && next_print_count != '1) begin
            next_print_count = next_print_count + 1'b1; // RULE10
        end

        next_error_held = error_post
                        || (error_held && !clear_all
                            && !(cmd.valid && cmd.code == CMD_CLR_ERR)); // RULE11 RULE7

        // request-service is raised on the rising master summary, dropped by a poll
        next_rqs = (mss && !mss_q) || (rqs && !serial_poll && mss); // RULE15

        next_talker_drive = talker_addressed && !serial_mode && out_count != '0; // RULE17
        next_serial_send  = serial_mode && out_count != '0; // RULE8
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `GRP_COUNT; i++) begin
                grp[i] <= '{`FLAGS_RESET, `FLAGS_RESET, `ENABLE_RESET, `ENABLE_RESET}; // RULE23
            end
            esr          <= `FLAGS_RESET;
            ese          <= `ENABLE_RESET;
            sre          <= `ENABLE_RESET;
            out_count    <= '0;
            print_count  <= '0;
            error_held   <= 1'b0;
            rqs          <= 1'b0;
            mss_q        <= 1'b0;
            rsp_valid    <= 1'b0;
            rsp_data     <= `BYTE_ZERO;
            srq          <= 1'b0;
            talker_drive <= 1'b0;
            serial_send  <= 1'b0;
        end else begin
            grp          <= next_grp;
            esr          <= next_esr;
            ese          <= next_ese;
            sre          <= next_sre;
            out_count    <= next_out_count;
            print_count  <= next_print_count;
            error_held   <= next_error_held;
            rqs          <= next_rqs;
            mss_q        <= mss;
            rsp_valid    <= next_rsp_valid;
            rsp_data     <= next_rsp_data;
            srq          <= next_rqs;
            talker_drive <= next_talker_drive;
            serial_send  <= next_serial_send;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_line_rise;
        line_sync[0] && !line_prev[0];
    endsequence

    property p_hist_set;
        @(posedge core_clk) disable iff (rst) s_line_rise |=> grp[`GRP_LINE].hist[0];
    endproperty
    a_hist_set: assert property (p_hist_set) else $error("history bit missed a rise"); // RULE2

    property p_read_keeps_event;
        @(posedge core_clk) disable iff (rst)
            (rd_lhist && rise[`GRP_LINE][1]) |=> grp[`GRP_LINE].hist[1];
    endproperty
    a_read_keeps_event: assert property (p_read_keeps_event) else $error("event lost on read"); // RULE22

    property p_read_clears;
        @(posedge core_clk) disable iff (rst)
            (rd_lloss && fall[`GRP_LINE] == '0) |=> grp[`GRP_LINE].loss == '0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("loss not cleared by read"); // RULE3

    property p_esr_read_clear;
        @(posedge core_clk) disable iff (rst)
            (cmd.valid && cmd.code == CMD_RD_ESR && std_event == '0 && !resp_pop) |=> esr == '0;
    endproperty
    a_esr_read_clear: assert property (p_esr_read_clear) else $error("event register kept on read"); // RULE20

    property p_cls_keeps_queue;
        @(posedge core_clk) disable iff (rst)
            (clear_all && !resp_push && !resp_pop) |=> (out_count == $past(out_count) && !error_held
                                                       || $past(error_post));
    endproperty
    a_cls_keeps_queue: assert property (p_cls_keeps_queue) else $error("clear touched output queue"); // RULE7

    property p_mav_rsp;
        @(posedge core_clk) disable iff (rst)
            (cmd.valid && cmd.code == CMD_RD_STB && !serial_poll)
                |=> rsp_valid && rsp_data[`SB_MSG_AVAIL] == $past(out_count != '0)
                    && !rsp_data[`SB_UNUSED];
    endproperty
    a_mav_rsp: assert property (p_mav_rsp) else $error("status byte answer wrong"); // RULE9

    property p_srq_on_mss;
        @(posedge core_clk) disable iff (rst) (mss && !mss_q) |=> srq;
    endproperty
    a_srq_on_mss: assert property (p_srq_on_mss) else $error("service request not raised"); // RULE15

    property p_no_talk_empty;
        @(posedge core_clk) disable iff (rst) talker_drive |-> $past(out_count != '0);
    endproperty
    a_no_talk_empty: assert property (p_no_talk_empty) else $error("talked with empty queue"); // RULE17

    property p_sre_fixed;
        @(posedge core_clk) disable iff (rst) !sre[`SB_MASTER_SUM];
    endproperty
    a_sre_fixed: assert property (p_sre_fixed) else $error("master enable became programmable"); // RULE14

    property p_print_remote;
        @(posedge core_clk) disable iff (rst)
            (!print_remote && !clear_all) |=> print_count <= $past(print_count);
    endproperty
    a_print_remote: assert property (p_print_remote) else $error("printout queued while local"); // RULE10

endmodule

/* test/controller_model.sv */
`timescale 1ns/10ps
// ****************************************
// remote controller: drains the output queue
// ****************************************
module controller_model (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic talker_drive,
    input  wire logic serial_send,
    input  wire logic stall,
    input  wire logic rude,
    output logic      resp_pop
);
    int unsigned gap;

    // one read at a time; the gap covers the one-cycle lag of the ready flags,
    // otherwise a stale flag would look like a read of an empty queue
    always @(negedge core_clk or posedge rst) begin
        if (rst) begin
            resp_pop = 1'b0;
            gap = 0;
        end else begin
            resp_pop = 1'b0;
            if (gap != 0) begin
                gap--;
            end else if (rude || (!stall && (talker_drive || serial_send))) begin
                resp_pop = 1'b1;
                gap = 3;
            end
        end
    end
endmodule

/* test/tb.sv */
`timescale 1ns/10ps
module tb;
    import status_srq_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    cmd_req_t   cmd = '0;
    logic       serial_poll = 1'b0;
    logic       serial_mode = 1'b0;
    logic       talker_addressed = 1'b0;
    logic [7:0] line_level_pin = 8'h00;
    logic [7:0] intf_level_pin = 8'h00;
    logic [7:0] std_event = 8'h00;
    logic       resp_push = 1'b0;
    logic       print_push = 1'b0;
    logic       print_pop = 1'b0;
    logic       print_remote = 1'b0;
    logic       error_post = 1'b0;
    logic       stall = 1'b1;
    logic       rude = 1'b0;
    logic       resp_pop;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       srq;
    logic       talker_drive;
    logic       serial_send;
    int         mismatches = 0;
    int         cmp_count = 0;
    cmd_t       en_wr [6] = '{CMD_WR_SRE, CMD_WR_ESE, CMD_WR_LHE, CMD_WR_LLE, CMD_WR_IHE, CMD_WR_ILE};
    cmd_t       en_rd [6] = '{CMD_RD_SRE, CMD_RD_ESE, CMD_RD_LHE, CMD_RD_LLE, CMD_RD_IHE, CMD_RD_ILE};

    always #2.5 core_clk = ~core_clk;

    status_reporting_srq #(.QCOUNT_W(4)) u_status_reporting_srq (
        .core_clk(core_clk), .rst(rst), .cmd(cmd), .serial_poll(serial_poll),
        .line_level_pin(line_level_pin), .intf_level_pin(intf_level_pin), .std_event(std_event),
        .resp_push(resp_push), .resp_pop(resp_pop), .serial_mode(serial_mode),
        .talker_addressed(talker_addressed), .print_push(print_push), .print_pop(print_pop),
        .print_remote(print_remote), .error_post(error_post), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .srq(srq), .talker_drive(talker_drive), .serial_send(serial_send)
    );

    controller_model u_controller_model (
        .core_clk(core_clk), .rst(rst), .talker_drive(talker_drive), .serial_send(serial_send),
        .stall(stall), .rude(rude), .resp_pop(resp_pop)
    );

    // ****************************************
    // access tasks
    // ****************************************
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wr(input cmd_t c, input logic [7:0] d);
        @(negedge core_clk);
        cmd = '{1'b1, c, d};
        @(negedge core_clk);
        cmd = '0;
    endtask

    // answer is a one-cycle pulse, so it is caught within a short bounded look
    task automatic answer(input logic [7:0] exp);
        int i;
        for (i = 0; i < 4 && rsp_valid !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        if (rsp_valid !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: no answer", $time);
            results();
        end else begin
            chk(rsp_data, exp);
        end
    endtask

    task automatic rdc(input cmd_t c, input logic [7:0] exp);
        wr(c, 8'h00);
        answer(exp);
    endtask

    task automatic poll(input logic [7:0] exp);
        @(negedge core_clk);
        serial_poll = 1'b1;
        @(negedge core_clk);
        serial_poll = 1'b0;
        answer(exp);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        tick(5);
        rst = 1'b0;
        for (int k = 0; k < 6; k++) begin
            rdc(en_rd[k], 8'h00);
            wr(en_wr[k], 8'h5a);
            rdc(en_rd[k], (k == 0) ? 8'h1a : 8'h5a);
            wr(en_wr[k], 8'h00);
        end
        rdc(CMD_RD_STB, 8'h00);
        $display("test enables done");

        line_level_pin = 8'h05;
        tick(5);
        rdc(CMD_RD_LINE, 8'h05);
        rdc(CMD_RD_LHIST, 8'h05);
        rdc(CMD_RD_LHIST, 8'h00);
        rdc(CMD_RD_LLOSS, 8'h00);
        line_level_pin = 8'h01;
        tick(5);
        line_level_pin = 8'h05;
        tick(5);
        rdc(CMD_RD_LHIST, 8'h04);
        rdc(CMD_RD_LLOSS, 8'h04);
        wr(CMD_WR_LLE, 8'h01);
        line_level_pin = 8'h04;
        tick(5);
        rdc(CMD_RD_STB, 8'h04);
        wr(CMD_WR_SRE, 8'h04);
        tick(3);
        rdc(CMD_RD_STB, 8'h44);
        chk({7'h00, srq}, 8'h01);
        poll(8'h44);
        tick(2);
        chk({7'h00, srq}, 8'h00);
        rdc(CMD_RD_LLOSS, 8'h01);
        tick(3);
        rdc(CMD_RD_STB, 8'h00);
        wr(CMD_WR_SRE, 8'h00);
        // bit 1 rises in the very cycle the read is taken: it must wait for the next read
        line_level_pin = 8'h06;
        tick(1);
        rdc(CMD_RD_LHIST, 8'h00);
        rdc(CMD_RD_LHIST, 8'h02);
        $display("test line group done");

        wr(CMD_WR_IHE, 8'h80);
        intf_level_pin = 8'h80;
        tick(5);
        rdc(CMD_RD_STB, 8'h08);
        wr(CMD_WR_IHE, 8'h00);
        tick(2);
        rdc(CMD_RD_STB, 8'h00);
        rdc(CMD_RD_IHIST, 8'h80);
        intf_level_pin = 8'h00;
        tick(5);
        rdc(CMD_RD_ILOSS, 8'h80);
        rdc(CMD_RD_INTF, 8'h00);
        $display("test interface group done");

        wr(CMD_WR_ESE, 8'h01);
        std_event = 8'h01;
        tick(1);
        std_event = 8'h00;
        tick(3);
        rdc(CMD_RD_STB, 8'h20);
        rdc(CMD_RD_ESR, 8'h01);
        rdc(CMD_RD_ESR, 8'h00);
        $display("test event group done");

        resp_push = 1'b1;
        tick(1);
        resp_push = 1'b0;
        tick(3);
        rdc(CMD_RD_STB, 8'h10);
        chk({7'h00, talker_drive}, 8'h00);
        talker_addressed = 1'b1;
        tick(3);
        chk({7'h00, talker_drive}, 8'h01);
        stall = 1'b0;
        tick(8);
        chk({7'h00, talker_drive}, 8'h00);
        talker_addressed = 1'b0;
        serial_mode = 1'b1;
        stall = 1'b1;
        resp_push = 1'b1;
        tick(1);
        resp_push = 1'b0;
        tick(3);
        chk({7'h00, serial_send}, 8'h01);
        stall = 1'b0;
        tick(8);
        chk({7'h00, serial_send}, 8'h00);
        serial_mode = 1'b0;
        rude = 1'b1;
        tick(2);
        rude = 1'b0;
        tick(3);
        rdc(CMD_RD_ESR, 8'h04);
        $display("test output queue done");

        print_push = 1'b1;
        tick(1);
        print_push = 1'b0;
        tick(3);
        rdc(CMD_RD_STB, 8'h00);
        print_remote = 1'b1;
        print_push = 1'b1;
        tick(1);
        print_push = 1'b0;
        tick(3);
        rdc(CMD_RD_STB, 8'h02);
        print_pop = 1'b1;
        tick(1);
        print_pop = 1'b0;
        error_post = 1'b1;
        tick(1);
        error_post = 1'b0;
        tick(3);
        rdc(CMD_RD_STB, 8'h01);
        wr(CMD_CLR_ERR, 8'h00);
        tick(2);
        rdc(CMD_RD_STB, 8'h00);
        $display("test print and error done");

        stall = 1'b1;
        wr(CMD_WR_LLE, 8'h04);
        resp_push = 1'b1;
        print_push = 1'b1;
        error_post = 1'b1;
        std_event = 8'h01;
        line_level_pin = 8'h00;
        tick(1);
        resp_push = 1'b0;
        print_push = 1'b0;
        error_post = 1'b0;
        std_event = 8'h00;
        tick(5);
        rdc(CMD_RD_STB, 8'h37);
        wr(CMD_CLEAR, 8'h00);
        tick(3);
        rdc(CMD_RD_STB, 8'h10);
        rdc(CMD_RD_LLE, 8'h04);
        rdc(CMD_RD_LLOSS, 8'h00);
        stall = 1'b0;
        tick(8);
        $display("test clear status done");
        results();
    end

    initial begin
        tick(20000);
        mismatches++;
        $display("wrong value at %0t: run too long", $time);
        results();
    end
endmodule
